// ---- rtl/gain_trim_cfg.svh ----
// Register offsets, field positions and reset values of the trim block
`ifndef GAIN_TRIM_CFG_SVH
`define GAIN_TRIM_CFG_SVH

// Widths
`define GT_CODE_W 24
`define GT_ADDR_W 8

// Register offsets
`define GT_OFF_CH0 8'h0e
`define GT_GAIN_CH0 8'h11
`define GT_OFF_CH1 8'h14
`define GT_GAIN_CH1 8'h17
`define GT_TEMPCO 8'h1a
`define GT_CTRL 8'h1b
`define GT_STAT_CH0 8'h20
`define GT_STAT_CH1 8'h21

// Control field positions
`define GT_CTRL_OFF_BIT 0
`define GT_CTRL_GAIN_BIT 1

// Reset values
`define GT_TRIM_RST 24'h000000
`define GT_TEMPCO_RST 8'h42
`define GT_CTRL_RST 2'h0
`define GT_STAT_RST 24'h000000

`endif

// ---- rtl/gain_trim_pkg.sv ----
// Types shared by the trim block and its testbench
package gain_trim_pkg;

  // One code for each of the two channels
  typedef struct packed {
    logic [23:0] ch1;
    logic [23:0] ch0;
  } code_pair_t;

  // Correction enables held in the control register
  typedef struct packed {
    logic gain_en;
    logic offset_en;
  } ctrl_t;

endpackage : gain_trim_pkg

// ---- rtl/trim_channel.sv ----
// One channel: offset add, then one-plus-trim gain multiply
`timescale 1ns/1ps
`include "gain_trim_cfg.svh"

module trim_channel #(
  parameter int W = `GT_CODE_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Raw sample
  input wire logic valid_in,
  input wire logic [W-1:0] code_in,
  // Trim settings
  input wire logic [W-1:0] offset_trim_in,
  input wire logic [W-1:0] gain_trim_in,
  input wire logic offset_en_in,
  input wire logic gain_en_in,
  // Corrected sample
  output logic valid_out,
  output logic [W-1:0] code_out
);

  // Exactly 1.0 in the gain format, one integer bit above W-1 fraction bits
  localparam logic signed [W:0] GAIN_ONE = {2'b01, {(W-1){1'b0}}};

  logic signed [W:0] sum;
  logic signed [W-1:0] offs_q;
  logic offs_vld_q;
  logic signed [W:0] gain;
  logic signed [2*W:0] prod;
  logic signed [W+1:0] scaled;

  // Saturate a wider signed value back to W bits instead of wrapping
  function automatic logic [W-1:0] clamp(input logic signed [W+1:0] v);
    if (v[W+1:W-1] == {3{v[W+1]}})
      clamp = v[W-1:0];
    else
      clamp = v[W+1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
  endfunction : clamp

  // Signed offset sum, one guard bit
  assign sum = $signed({offset_trim_in[W-1], offset_trim_in}) +
               $signed({code_in[W-1], code_in});
  // Trim word taken as signed fraction plus one
  assign gain = $signed({gain_trim_in[W-1], gain_trim_in}) + GAIN_ONE;
  // Multiply the stage-one code: offset-corrected when offset enable is set, else the raw one
  assign prod = offs_q * gain;
  // Drop the fraction bits so the output keeps the input format
  assign scaled = prod[2*W:W-1];

  // Stage one: offset correction
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      offs_q <= '0;
      offs_vld_q <= 1'b0;
    end
    else
    begin
      offs_vld_q <= valid_in;
      if (valid_in)
        offs_q <= offset_en_in ? clamp({sum[W], sum}) : code_in;
    end
  end

  // Stage two: gain correction or pass-through
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      code_out <= '0;
      valid_out <= 1'b0;
    end
    else
    begin
      valid_out <= offs_vld_q;
      if (offs_vld_q)
        code_out <= gain_en_in ? clamp(scaled) : offs_q;
    end
  end

  // Two-cycle latency from sample to result
  latency_fixed_a: assert property (@(posedge clk_in) disable iff (rst_in)
    valid_in |-> ##2 valid_out)
    else $error("corrected sample late or missing");

  // Offset trim alone lands on a zero code
  offset_add_a: assert property (@(posedge clk_in) disable iff (rst_in)
    valid_in && offset_en_in && code_in == '0 |=>
      offs_q == $past(offset_trim_in))
    else $error("offset trim not added to code");

  // With both corrections off the code passes unchanged
  gain_bypass_a: assert property (@(posedge clk_in) disable iff (rst_in)
    valid_in && !offset_en_in ##1 !gain_en_in |=>
      code_out == $past(code_in, 2))
    else $error("code altered with gain correction off");

  // A zero trim word gives exactly unity gain
  unity_gain_a: assert property (@(posedge clk_in) disable iff (rst_in)
    valid_in && !offset_en_in ##1 gain_en_in && gain_trim_in == '0 |=>
      code_out == $past(code_in, 2))
    else $error("zero trim word not unity gain");

  // Most negative trim word gives zero gain
  zero_gain_a: assert property (@(posedge clk_in) disable iff (rst_in)
    offs_vld_q && gain_en_in && gain_trim_in == 24'h800000 |=>
      code_out == '0)
    else $error("minimum trim word not zero gain");

  // Trim step of two on minus half scale moves the result by one
  lsb_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
    offs_vld_q && gain_en_in && gain_trim_in == 24'h000002 &&
      offs_q == 24'hc00000 |=> code_out == 24'hbfffff)
    else $error("trim step weight wrong");

endmodule : trim_channel

// ---- rtl/channel_gain_trim.sv ----
// Two-channel offset and gain trim with its register file
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "gain_trim_cfg.svh"

// Overview of operation
// - Gain trim word is 24-bit signed fraction, minus one to below one.
// - Enabled gain multiplies channel code by one plus trim word.
// - Gain multiply acts on the offset-corrected code when offset enable is set, else on the raw code.
// - One trim step changes the multiplier by two to minus twenty-three.
// - Gain enable low passes the code through without gain correction.
// - Clearing gain enable keeps the stored gain trim words.
// - Tempco trim is eight bits, read-write, reset value 0x42.
// - Offset enable adds the signed 24-bit offset trim to raw code.

module channel_gain_trim (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  // Register port
  input wire logic [`GT_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [`GT_CODE_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [`GT_CODE_W-1:0] REG_RDATA_OUT,
  // Raw samples from the converters
  input wire logic SAMPLE_VALID_IN,
  input wire gain_trim_pkg::code_pair_t SAMPLE_IN,
  // Corrected samples
  output logic CORR_VALID_OUT,
  output gain_trim_pkg::code_pair_t CORR_OUT
);

  localparam int W = `GT_CODE_W;

  logic [W-1:0] gain0_q;
  logic [W-1:0] gain1_q;
  logic [W-1:0] off0_q;
  logic [W-1:0] off1_q;
  logic [7:0] tempco_q;
  gain_trim_pkg::ctrl_t ctrl_q;
  logic [W-1:0] stat0_q;
  logic [W-1:0] stat1_q;
  logic [W-1:0] res0;
  logic [W-1:0] res1;
  logic vld0;
  logic [W-1:0] rdata_d;
  logic wr_ctrl;
  logic wr_gain;

  // Decoded write hits used by the assertions below
  assign wr_ctrl = REG_WR_IN && REG_ADDR_IN == `GT_CTRL;
  assign wr_gain = REG_WR_IN &&
                   (REG_ADDR_IN == `GT_GAIN_CH0 ||
                    REG_ADDR_IN == `GT_GAIN_CH1);

  // Gain trim words, written only by their own addresses
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      gain0_q <= `GT_TRIM_RST;
      gain1_q <= `GT_TRIM_RST;
    end
    else if (REG_WR_IN)
    begin
      // The enable bit lives elsewhere, so clearing it leaves these intact
      if (REG_ADDR_IN == `GT_GAIN_CH0)
        gain0_q <= REG_WDATA_IN;
      if (REG_ADDR_IN == `GT_GAIN_CH1)
        gain1_q <= REG_WDATA_IN;
    end
  end

  // Offset trim words
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      off0_q <= `GT_TRIM_RST;
      off1_q <= `GT_TRIM_RST;
    end
    else if (REG_WR_IN)
    begin
      if (REG_ADDR_IN == `GT_OFF_CH0)
        off0_q <= REG_WDATA_IN;
      if (REG_ADDR_IN == `GT_OFF_CH1)
        off1_q <= REG_WDATA_IN;
    end
  end

  // Reference tempco trim, eight bits in the low lane
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
      tempco_q <= `GT_TEMPCO_RST;
    else if (REG_WR_IN && REG_ADDR_IN == `GT_TEMPCO)
      tempco_q <= REG_WDATA_IN[7:0];
  end

  // Correction enables; both off after reset so codes start untouched
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
      ctrl_q <= `GT_CTRL_RST;
    else if (wr_ctrl)
    begin
      ctrl_q.offset_en <= REG_WDATA_IN[`GT_CTRL_OFF_BIT];
      ctrl_q.gain_en <= REG_WDATA_IN[`GT_CTRL_GAIN_BIT];
    end
  end

  // Channel datapaths share the enables but hold their own trims
  trim_channel #(
    .W(W)
  ) u_chan0 (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .valid_in(SAMPLE_VALID_IN),
    .code_in(SAMPLE_IN.ch0),
    .offset_trim_in(off0_q),
    .gain_trim_in(gain0_q),
    .offset_en_in(ctrl_q.offset_en),
    .gain_en_in(ctrl_q.gain_en),
    .valid_out(vld0),
    .code_out(res0)
  );

  trim_channel #(
    .W(W)
  ) u_chan1 (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .valid_in(SAMPLE_VALID_IN),
    .code_in(SAMPLE_IN.ch1),
    .offset_trim_in(off1_q),
    .gain_trim_in(gain1_q),
    .offset_en_in(ctrl_q.offset_en),
    .gain_en_in(ctrl_q.gain_en),
    .valid_out(),
    .code_out(res1)
  );

  // Both channels run in lockstep, so one valid serves the pair
  assign CORR_VALID_OUT = vld0;
  assign CORR_OUT.ch0 = res0;
  assign CORR_OUT.ch1 = res1;

  // Last corrected codes, kept for software to inspect
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      stat0_q <= `GT_STAT_RST;
      stat1_q <= `GT_STAT_RST;
    end
    else if (vld0)
    begin
      stat0_q <= res0;
      stat1_q <= res1;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    rdata_d = '0;
    case (REG_ADDR_IN)
      `GT_GAIN_CH0: rdata_d = gain0_q;
      `GT_GAIN_CH1: rdata_d = gain1_q;
      `GT_OFF_CH0: rdata_d = off0_q;
      `GT_OFF_CH1: rdata_d = off1_q;
      `GT_TEMPCO: rdata_d = {16'h0000, tempco_q};
      `GT_CTRL: rdata_d = {22'h0, ctrl_q};
      `GT_STAT_CH0: rdata_d = stat0_q;
      `GT_STAT_CH1: rdata_d = stat1_q;
      default: rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
      REG_RDATA_OUT <= '0;
    else
      REG_RDATA_OUT <= REG_RD_IN ? rdata_d : '0;
  end

  // Tempco trim comes out of reset at its default
  tempco_reset_a: assert property (@(posedge CLOCK_IN)
    $past(SYS_RST_IN) && !SYS_RST_IN |-> tempco_q == 8'h42)
    else $error("tempco trim reset value wrong");

  // Tempco trim reads back in the low byte
  tempco_read_a: assert property (@(posedge CLOCK_IN)
    disable iff (SYS_RST_IN)
    REG_RD_IN && REG_ADDR_IN == `GT_TEMPCO |=>
      REG_RDATA_OUT == {16'h0000, $past(tempco_q)})
    else $error("tempco trim readback wrong");

  // Control writes that clear the gain enable never disturb the stored gain trims
  trim_hold_a: assert property (@(posedge CLOCK_IN)
    disable iff (SYS_RST_IN)
    wr_ctrl && !REG_WDATA_IN[`GT_CTRL_GAIN_BIT] |=>
      gain0_q == $past(gain0_q) && gain1_q == $past(gain1_q))
    else $error("gain trim changed by enable write");

  // Gain trim write lands and reads back two cycles later
  gain_write_a: assert property (@(posedge CLOCK_IN)
    disable iff (SYS_RST_IN)
    wr_gain && REG_ADDR_IN == `GT_GAIN_CH0 ##1
      REG_RD_IN && REG_ADDR_IN == `GT_GAIN_CH0 && !REG_WR_IN |=>
      REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
    else $error("gain trim readback wrong");

  // Data appear only after a read strobe
  read_idle_a: assert property (@(posedge CLOCK_IN)
    disable iff (SYS_RST_IN)
    !REG_RD_IN |=> REG_RDATA_OUT == '0)
    else $error("read data without read strobe");

endmodule : channel_gain_trim

// ---- verification/channel_gain_trim_tb.sv ----
// Self-checking bench for the two-channel offset and gain trim block
`timescale 1ns/1ps
`include "gain_trim_cfg.svh"

module channel_gain_trim_tb;
  logic clk;
  logic rst;
  logic [7:0] addr;
  logic [23:0] wdata;
  logic wr;
  logic rd;
  logic [23:0] rdata;
  logic s_valid;
  gain_trim_pkg::code_pair_t sample;
  logic c_valid;
  gain_trim_pkg::code_pair_t corr;
  int n_errors;
  int checks;
  logic [23:0] e0;
  logic [23:0] e1;
  // Per case: raw0, offset0, gain0, raw1, offset1, gain1
  // Last case: zero code meets offset, zero trim gives unity gain
  logic [23:0] tab [5][6] = '{
    '{24'h100000, 24'h100000, 24'h400000, 24'hc00000, 24'h000000, 24'h000002},
    '{24'h400000, 24'h000005, 24'h000002, 24'hffffff, 24'hfffffe, 24'hc00000},
    '{24'h7ffff0, 24'h000100, 24'h7fffff, 24'h800000, 24'hffff00, 24'h7fffff},
    '{24'h000003, 24'h000000, 24'hc00000, 24'h2aaaaa, 24'h000000, 24'h800000},
    '{24'h000000, 24'h123456, 24'h000000, 24'h7fffff, 24'h000001, 24'h000000}};

  channel_gain_trim dut (
    .CLOCK_IN(clk),
    .SYS_RST_IN(rst),
    .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr),
    .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata),
    .SAMPLE_VALID_IN(s_valid),
    .SAMPLE_IN(sample),
    .CORR_VALID_OUT(c_valid),
    .CORR_OUT(corr)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // Clamp to the 24-bit two's complement range
  function automatic longint sat(input longint v);
    if (v > 64'sh7fffff)
      return 64'sh7fffff;
    if (v < -64'sh800000)
      return -64'sh800000;
    return v;
  endfunction : sat

  // Offset first, then one-plus-trim gain; shift floors toward minus infinity
  function automatic logic [23:0] model(input logic [23:0] raw, off, gn,
                                        input logic oe, ge);
    longint o;
    o = longint'($signed(raw));
    if (oe)
      o = sat(o + longint'($signed(off)));
    if (ge)
      o = sat((o * (longint'($signed(gn)) + 64'sh800000)) >>> 23);
    return o[23:0];
  endfunction : model

  task automatic chk(input string name, input logic [23:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Write then read the same place with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [23:0] d,
                       input string name);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(name, d, rdata);
  endtask : wr_rd

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [23:0] exp,
                        input string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask : rd_reg

  // One sample pair; the result pulse stands in the cycle before the
  // second edge after the take, so it is seen just after the first one
  task automatic smp(input logic [23:0] a, b, ea, eb);
    @(posedge clk);
    sample <= '{ch1: b, ch0: a};
    s_valid <= 1'b1;
    @(posedge clk);
    s_valid <= 1'b0;
    #1 chk("valid early", 24'h0, {23'h0, c_valid});
    @(posedge clk);
    #1 chk("valid", 24'h1, {23'h0, c_valid});
    chk("ch0 code", ea, corr.ch0);
    chk("ch1 code", eb, corr.ch1);
  endtask : smp

  task automatic summarize;
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // Watchdog: the full sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 24'h0;
    wr = 1'b0;
    rd = 1'b0;
    s_valid = 1'b0;
    sample = '0;
    n_errors = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1 chk("corr after reset", 24'h0, corr.ch0 | corr.ch1);
    rd_reg(`GT_GAIN_CH0, 24'h0, "gain0 reset");
    rd_reg(`GT_GAIN_CH1, 24'h0, "gain1 reset");
    rd_reg(`GT_TEMPCO, 24'h000042, "tempco reset");
    rd_reg(`GT_CTRL, 24'h0, "ctrl reset");
    // Deliberate tempco calibration write, the only one the bench makes to that register
    wr_reg(`GT_TEMPCO, 24'h0000a5);
    rd_reg(`GT_TEMPCO, 24'h0000a5, "tempco rw");
    @(posedge clk);
    #1 chk("rdata idle", 24'h0, rdata);
    // Each case runs under all four enable combinations
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(`GT_OFF_CH0, tab[i][1]);
      wr_rd(`GT_GAIN_CH0, tab[i][2], "gain0 rw");
      wr_reg(`GT_OFF_CH1, tab[i][4]);
      wr_reg(`GT_GAIN_CH1, tab[i][5]);
      rd_reg(`GT_GAIN_CH1, tab[i][5], "gain1 rw");
      for (int m = 0; m < 4; m++)
      begin
        wr_reg(`GT_CTRL, m[23:0]);
        e0 = model(tab[i][0], tab[i][1], tab[i][2], m[0], m[1]);
        e1 = model(tab[i][3], tab[i][4], tab[i][5], m[0], m[1]);
        smp(tab[i][0], tab[i][3], e0, e1);
      end
      // Enable cleared and set again above; stored trim must survive
      rd_reg(`GT_GAIN_CH0, tab[i][2], "gain0 kept");
    end
    // Status is read only; unmapped places read zero
    wr_reg(`GT_STAT_CH0, 24'h654321);
    rd_reg(`GT_STAT_CH0, e0, "status ch0");
    wr_reg(8'h30, 24'hffffff);
    rd_reg(8'h30, 24'h0, "unmapped");
    // Reset again in mid-run: written settings fall back to defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`GT_TEMPCO, 24'h000042, "tempco re-reset");
    rd_reg(`GT_GAIN_CH0, 24'h0, "gain0 re-reset");
    smp(24'h123456, 24'h654321, 24'h123456, 24'h654321);
    summarize();
  end
endmodule : channel_gain_trim_tb
